// *** hw/eepc_consts.svh ***
// constant definitions for the program/erase control block
`ifndef EEPC_CONSTS_SVH
`define EEPC_CONSTS_SVH
// register offsets (chosen locally)
`define EEPC_OFF_CTRL 4'h0
`define EEPC_OFF_DIV 4'h1
`define EEPC_OFF_PROT 4'h2
`define EEPC_OFF_STAT 4'h3
`define EEPC_OFF_MASK 4'h4
`define EEPC_OFF_LADDR 4'h5
`define EEPC_OFF_LDATL 4'h6
`define EEPC_OFF_LDATH 4'h7
`define EEPC_OFF_INFO 4'h8
// control register bit positions
`define EEPC_B_PGM 0
`define EEPC_B_LAT 1
`define EEPC_B_ERASE 2
`define EEPC_B_ROW 3
`define EEPC_B_BYTE 4
`define EEPC_B_AUTO 5
`define EEPC_B_BULK_PROTECT 7
// control register reset value
`define EEPC_CTRL_RST 8'h80
// status bits
`define EEPC_S_DONE 0
`define EEPC_S_REFUSE 1
// program and erase times
`define EEPC_T_PROG_US 10000
`define EEPC_T_ERASE_US 10000
// divider ticks are taken as 1 us each
`define EEPC_TICK_NS 1000
// array geometry
`define EEPC_ROW_BYTES 32
`endif

// *** hw/eepc_pkg.sv ***
// types shared by the program/erase control block
package eepc_pkg;
    // erase size selection
    typedef enum logic [1:0] {
        EEPC_SZ_PROG = 2'b00,
        EEPC_SZ_LOC = 2'b01,
        EEPC_SZ_ROW = 2'b10,
        EEPC_SZ_BULK = 2'b11
    } eepc_size_e;
    // cycle sequencer states
    typedef enum logic [1:0] {
        EEPC_ST_IDLE = 2'b00,
        EEPC_ST_RUN = 2'b01,
        EEPC_ST_DONE = 2'b10,
        EEPC_ST_HOLD = 2'b11
    } eepc_state_e;
endpackage

// *** hw/eepc_tick_if.sv ***
// interface carrying the timebase between divider and timer
interface eepc_tick_if;
    logic tick;  // one-cycle timebase pulse
    logic run;   // timer run enable; low aborts a count
    logic start; // one-cycle timer start
    logic done;  // one-cycle timer expiry
    modport div_mp(output tick);
    modport tmr_mp(input tick, input start, input run, output done);
    modport ctl_mp(input tick, output start, output run, input done);
endinterface

// *** hw/eepc_divider.sv ***
// timebase divider that makes one-cycle tick pulses
`include "eepc_consts.svh"
module eepc_divider (
    input wire logic clk,
    input wire logic rst,
    input wire logic [9:0] div_val,
    eepc_tick_if.div_mp tk
);
    import eepc_pkg::*;
    logic [9:0] cnt_r; // counts system clocks up to divider value

    // divider counter; zero divider gives no tick at all
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 10'h000;
        end else if (div_val == 10'h000 || cnt_r >= div_val - 10'h001) begin
            cnt_r <= 10'h000;
        end else begin
            cnt_r <= cnt_r + 10'h001;
        end
    end

    // tick pulse when the count wraps
    assign tk.tick = (div_val != 10'h000) && (cnt_r >= div_val - 10'h001);
endmodule

// *** hw/eepc_timer.sv ***
// program/erase cycle timer counted in timebase ticks
`include "eepc_consts.svh"
module eepc_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] len,
    eepc_tick_if.tmr_mp tk
);
    import eepc_pkg::*;
    logic [15:0] cnt_r; // ticks remaining
    logic live_r;       // counting in progress

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 16'h0000;
            live_r <= 1'b0;
        end else if (tk.start) begin
            cnt_r <= len;
            live_r <= 1'b1;
        end else if (!tk.run) begin
            // abort when the voltage is removed early
            live_r <= 1'b0;
        end else if (live_r && tk.tick) begin
            cnt_r <= cnt_r - 16'h0001;
            if (cnt_r == 16'h0001) begin
                live_r <= 1'b0;
            end
        end
    end

    // expiry pulse on the last tick
    assign tk.done = live_r && tk.run && tk.tick && (cnt_r == 16'h0001);
endmodule

// *** hw/eepc_top.sv ***
// program/erase control register and sequencer for the nonvolatile array
// Notes on behaviour
// - auto mode clears program enable at end
// - config bits frozen while program enable set
// - erase size from location/row bits
// - size bits ignored when programming
// - location erase byte or word by access
// - clear mode picks program or erase
// - latch enable routes buses to latches
// - latch enable locked if pgm or div zero
// - mode bits writable together or apart
// - program enable drives array voltage
// - program enable needs latch already set
// - both set at once: only latch sets
// - array writes ignored while programming
// - bulk protect refuses row and bulk
// - protected target never starts the machine
`include "eepc_consts.svh"
module eepc_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [11:0] arr_addr,
    input wire logic [15:0] arr_wdata,
    input wire logic arr_wr,
    input wire logic arr_word,
    output logic arr_read_mode,
    output logic [11:0] lat_addr,
    output logic [15:0] lat_data,
    output logic lat_word,
    output logic lat_erase,
    output eepc_pkg::eepc_size_e lat_size,
    output logic hv_on,
    output logic irq
);
    import eepc_pkg::*;

    // cycle length in ticks, rounded up
    localparam logic [15:0] PROG_TICKS =
        16'((`EEPC_T_PROG_US * 1000 + `EEPC_TICK_NS - 1) / `EEPC_TICK_NS);
    localparam logic [15:0] ERASE_TICKS =
        16'((`EEPC_T_ERASE_US * 1000 + `EEPC_TICK_NS - 1) / `EEPC_TICK_NS);

    logic [7:0] ctrl_r;     // control register
    logic [9:0] div_r;      // timebase divider value
    logic [7:0] prot_r;     // one protect bit per 512-byte block
    logic [1:0] stat_r;     // sticky event flags
    logic [1:0] mask_r;     // interrupt mask
    logic lat_valid_r;      // latches hold a loaded address
    eepc_state_e st_r;      // sequencer state
    eepc_tick_if tk();      // timebase wiring
    logic wr_ctrl;          // write to control register
    logic pgm_set_ok;       // program enable may be set now
    logic prot_hit;         // target is protected
    logic start_ok;         // cycle may start
    logic ev_done;          // cycle finished event
    logic ev_refuse;        // refused start event
    logic [1:0] stat_nxt;   // status after this cycle's sets and clears
    logic [1:0] mask_nxt;   // mask after this cycle's write

    // decode the size; helper used by the protection check and output
    function automatic eepc_size_e size_of(input logic [7:0] c);
        // size bits matter only for erase
        if (!c[`EEPC_B_ERASE]) begin
            return EEPC_SZ_PROG;
        // location wins over row, else bulk
        end else if (c[`EEPC_B_BYTE]) begin
            return EEPC_SZ_LOC;
        end else if (c[`EEPC_B_ROW]) begin
            return EEPC_SZ_ROW;
        end else begin
            return EEPC_SZ_BULK;
        end
    endfunction

    assign wr_ctrl = reg_wr && reg_addr == `EEPC_OFF_CTRL;
    // writing both at once sets only the latch
    assign pgm_set_ok = ctrl_r[`EEPC_B_LAT] && lat_valid_r;

    // control register; config bits locked while enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= `EEPC_CTRL_RST;
        end else begin
            // hardware clear at end of cycle in auto mode
            if (ev_done && ctrl_r[`EEPC_B_AUTO]) begin
                ctrl_r[`EEPC_B_PGM] <= 1'b0;
            end else if (wr_ctrl) begin
                if (!reg_wdata[`EEPC_B_PGM]) begin
                    ctrl_r[`EEPC_B_PGM] <= 1'b0;
                end else if (pgm_set_ok) begin
                    ctrl_r[`EEPC_B_PGM] <= 1'b1;
                end
            end
            // clear mode writable only when idle
            if (wr_ctrl && !ctrl_r[`EEPC_B_PGM]) begin
                ctrl_r[`EEPC_B_BULK_PROTECT] <= reg_wdata[`EEPC_B_BULK_PROTECT];
                ctrl_r[`EEPC_B_AUTO] <= reg_wdata[`EEPC_B_AUTO];
                ctrl_r[`EEPC_B_BYTE] <= reg_wdata[`EEPC_B_BYTE];
                ctrl_r[`EEPC_B_ROW] <= reg_wdata[`EEPC_B_ROW];
                ctrl_r[`EEPC_B_ERASE] <= reg_wdata[`EEPC_B_ERASE];
                // latch locked when divider is zero
                if (div_r != 10'h000) begin
                    ctrl_r[`EEPC_B_LAT] <= reg_wdata[`EEPC_B_LAT];
                end
            end
        end
    end

    // divider and protect registers; software may rewrite both any time program enable is clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= 10'h000;
            prot_r <= 8'h00;
        end else if (reg_wr && !ctrl_r[`EEPC_B_PGM]) begin
            if (reg_addr == `EEPC_OFF_DIV) begin
                div_r <= {2'b00, reg_wdata};
            end
            if (reg_addr == `EEPC_OFF_PROT) begin
                prot_r <= reg_wdata;
            end
        end
    end

    // programming latches; load from array writes while latch mode is on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lat_addr <= 12'h000;
            lat_data <= 16'h0000;
            lat_word <= 1'b0;
            lat_valid_r <= 1'b0;
        end else if (!ctrl_r[`EEPC_B_LAT]) begin
            lat_valid_r <= 1'b0;
        // array writes ignored during a cycle
        end else if (arr_wr && !ctrl_r[`EEPC_B_PGM]) begin
            // word access aligns and marks word size
            lat_addr <= arr_word ? {arr_addr[11:1], 1'b0} : arr_addr;
            lat_data <= arr_wdata;
            lat_word <= arr_word;
            lat_valid_r <= 1'b1;
        end
    end

    // protection check on the latched target
    always_comb begin
        prot_hit = prot_r[lat_addr[11:9]];
        // bulk protect refuses row and bulk erase
        if (ctrl_r[`EEPC_B_BULK_PROTECT] &&
            (size_of(ctrl_r) == EEPC_SZ_ROW || size_of(ctrl_r) == EEPC_SZ_BULK)) begin
            prot_hit = 1'b1;
        end
        if (size_of(ctrl_r) == EEPC_SZ_BULK && prot_r != 8'h00) begin
            prot_hit = 1'b1;
        end
    end
    assign start_ok = !prot_hit;

    // sequencer: idle, running, finished, or held after a refusal
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= EEPC_ST_IDLE;
        end else begin
            unique case (st_r)
                EEPC_ST_IDLE: begin
                    if (ctrl_r[`EEPC_B_PGM]) begin
                        st_r <= start_ok ? EEPC_ST_RUN : EEPC_ST_HOLD;
                    end
                end
                EEPC_ST_RUN: begin
                    if (!ctrl_r[`EEPC_B_PGM]) begin
                        st_r <= EEPC_ST_IDLE;
                    end else if (tk.done) begin
                        st_r <= EEPC_ST_DONE;
                    end
                end
                EEPC_ST_DONE: begin
                    // wait for software when auto finish is off
                    if (!ctrl_r[`EEPC_B_PGM]) begin
                        st_r <= EEPC_ST_IDLE;
                    end
                end
                EEPC_ST_HOLD: begin
                    if (!ctrl_r[`EEPC_B_PGM]) begin
                        st_r <= EEPC_ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign tk.start = st_r == EEPC_ST_IDLE && ctrl_r[`EEPC_B_PGM] && start_ok;
    assign tk.run = ctrl_r[`EEPC_B_PGM];
    assign ev_done = tk.done;
    assign ev_refuse = st_r == EEPC_ST_IDLE && ctrl_r[`EEPC_B_PGM] && !start_ok;

    eepc_divider u_div (
        .clk(clk),
        .rst(rst),
        .div_val(div_r),
        .tk(tk.div_mp)
    );

    // cycle timer driven by the divider tick
    eepc_timer u_tmr (
        .clk(clk),
        .rst(rst),
        .len(ctrl_r[`EEPC_B_ERASE] ? ERASE_TICKS : PROG_TICKS),
        .tk(tk.tmr_mp)
    );

    // next status and mask; irq follows these so it drops with the clear
    always_comb begin
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        // mask takes the written value as a whole
        if (reg_wr && reg_addr == `EEPC_OFF_MASK) begin
            mask_nxt = reg_wdata[1:0];
        end
        // write one to clear
        if (reg_wr && reg_addr == `EEPC_OFF_STAT) begin
            stat_nxt = stat_r & ~reg_wdata[1:0];
        end
        // a new event wins over a clear in the same cycle
        stat_nxt = stat_nxt | {ev_refuse, ev_done};
    end

    // sticky status and mask registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_r <= 2'b00;
            mask_r <= 2'b00;
        end else begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
        end
    end

    // array side outputs from flip-flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hv_on <= 1'b0;
            lat_erase <= 1'b0;
            lat_size <= EEPC_SZ_PROG;
            arr_read_mode <= 1'b1;
            irq <= 1'b0;
        end else begin
            // voltage only while a started cycle runs
            hv_on <= ctrl_r[`EEPC_B_PGM] && st_r == EEPC_ST_RUN && !tk.done;
            lat_erase <= ctrl_r[`EEPC_B_ERASE];
            lat_size <= size_of(ctrl_r);
            arr_read_mode <= !ctrl_r[`EEPC_B_LAT];
            // irq follows next status so a clear drops it at once
            irq <= |(stat_nxt & mask_nxt);
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `EEPC_OFF_CTRL: reg_rdata <= ctrl_r;
                `EEPC_OFF_DIV: reg_rdata <= div_r[7:0];
                `EEPC_OFF_PROT: reg_rdata <= prot_r;
                `EEPC_OFF_STAT: reg_rdata <= {6'h00, stat_r};
                `EEPC_OFF_MASK: reg_rdata <= {6'h00, mask_r};
                `EEPC_OFF_LADDR: reg_rdata <= lat_addr[11:4];
                `EEPC_OFF_LDATL: reg_rdata <= lat_data[7:0];
                `EEPC_OFF_LDATH: reg_rdata <= lat_data[15:8];
                `EEPC_OFF_INFO: reg_rdata <= {6'h00, st_r};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // program enable never set without latch
    a_pgm_needs_lat: assert property (@(posedge clk) disable iff (rst)
        $rose(ctrl_r[`EEPC_B_PGM]) |-> $past(ctrl_r[`EEPC_B_LAT]))
        else $error("program enable set without latch");
    a_both_set: assert property (@(posedge clk) disable iff (rst)
        (wr_ctrl && !ctrl_r[`EEPC_B_LAT] && !ctrl_r[`EEPC_B_PGM] && reg_wdata[1:0] == 2'b11)
        |=> !ctrl_r[`EEPC_B_PGM])
        else $error("program enable set together with latch");
    a_cfg_frozen: assert property (@(posedge clk) disable iff (rst)
        ctrl_r[`EEPC_B_PGM] && $past(ctrl_r[`EEPC_B_PGM]) |-> $stable(ctrl_r[7:1]))
        else $error("config changed while enabled");
    a_lat_divzero: assert property (@(posedge clk) disable iff (rst)
        (div_r == 10'h000) |=> $stable(ctrl_r[`EEPC_B_LAT]) || $past(div_r) != 10'h000)
        else $error("latch changed with zero divider");
    a_auto_clear: assert property (@(posedge clk) disable iff (rst)
        ev_done && ctrl_r[`EEPC_B_AUTO] |=> !ctrl_r[`EEPC_B_PGM])
        else $error("auto finish did not clear enable");
    a_refuse_hold: assert property (@(posedge clk) disable iff (rst)
        st_r == EEPC_ST_HOLD |-> !hv_on && !tk.done)
        else $error("refused cycle started");
    a_latch_hold: assert property (@(posedge clk) disable iff (rst)
        ctrl_r[`EEPC_B_PGM] && $past(ctrl_r[`EEPC_B_PGM]) |-> $stable(lat_data) && $stable(lat_addr))
        else $error("latch changed during cycle");
    a_hv_off: assert property (@(posedge clk) disable iff (rst)
        !ctrl_r[`EEPC_B_PGM] |=> !hv_on)
        else $error("voltage on without enable");
    // done event bit appears in status the cycle after
    a_status_set: assert property (@(posedge clk) disable iff (rst)
        ev_done |=> stat_r[`EEPC_S_DONE])
        else $error("done event not recorded");
    // interrupt line mirrors unmasked status
    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        irq == |(stat_r & mask_r))
        else $error("interrupt line disagrees with status");
    // erase size outputs follow the mode bits
    a_loc_size: assert property (@(posedge clk) disable iff (rst)
        ctrl_r[`EEPC_B_ERASE] && ctrl_r[`EEPC_B_BYTE] |=> lat_size == EEPC_SZ_LOC)
        else $error("location erase size wrong");
    a_prog_size: assert property (@(posedge clk) disable iff (rst)
        !ctrl_r[`EEPC_B_ERASE] |=> lat_size == EEPC_SZ_PROG)
        else $error("size bits used while programming");
    // latch mode takes the array out of normal reads
    a_read_mode: assert property (@(posedge clk) disable iff (rst)
        ctrl_r[`EEPC_B_LAT] |=> !arr_read_mode)
        else $error("read mode kept with latch on");
    // bulk protect sends row and bulk erase to hold
    a_bulk_refuse: assert property (@(posedge clk) disable iff (rst)
        st_r == EEPC_ST_IDLE && ctrl_r[`EEPC_B_PGM] && ctrl_r[`EEPC_B_BULK_PROTECT] &&
        ctrl_r[`EEPC_B_ERASE] && !ctrl_r[`EEPC_B_BYTE] |=> st_r == EEPC_ST_HOLD)
        else $error("protected erase was started");
    // a started cycle powers the array
    a_hv_run: assert property (@(posedge clk) disable iff (rst)
        st_r == EEPC_ST_RUN && ctrl_r[`EEPC_B_PGM] && !tk.done |=> hv_on)
        else $error("voltage missing during cycle");
endmodule

// *** verification/test_eeprom_program_erase_control.sv ***
// self-checking testbench for the program/erase control block
module test_eeprom_program_erase_control;
    timeunit 1ns;
    timeprecision 1ns;
    import eepc_pkg::*;
    logic clk, rst, reg_wr, reg_rd, arr_wr, arr_word, rd_q;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, ctl;
    logic [11:0] arr_addr, lat_addr, a;
    logic [15:0] arr_wdata, lat_data, d;
    logic arr_read_mode, lat_word, lat_erase, hv_on, irq;
    logic [31:0] rnd;
    eepc_size_e lat_size;
    int num_errors = 0;
    int num_checks = 0;
    int seed = 74;
    logic [7:0] exp_q[$]; // expected read data, oldest first
    string name_q[$];
    logic [7:0] ctl_tab [5] = '{8'h04, 8'h0C, 8'h14, 8'h1C, 8'h00};

    eepc_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_addr(arr_addr),
        .arr_wdata(arr_wdata), .arr_wr(arr_wr), .arr_word(arr_word),
        .arr_read_mode(arr_read_mode), .lat_addr(lat_addr), .lat_data(lat_data),
        .lat_word(lat_word), .lat_erase(lat_erase), .lat_size(lat_size), .hv_on(hv_on),
        .irq(irq));

    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // waits whole cycles and ends mid-cycle, where outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one-cycle write strobe; a clock edge passes before the next strobe
    task automatic reg_write(input logic [3:0] ad, input logic [7:0] wd);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // the expectation is queued; the watcher compares one cycle later
    task automatic reg_read(input logic [3:0] ad, input logic [7:0] e, input string what);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        name_q.push_back(what);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic arr_write(input logic [11:0] ad, input logic [15:0] wd, input logic w);
        @(posedge clk);
        arr_addr <= ad;
        arr_wdata <= wd;
        arr_word <= w;
        arr_wr <= 1'b1;
        @(posedge clk);
        arr_wr <= 1'b0;
    endtask

    // latch set, one array load, then program enable
    task automatic start_op(input logic [7:0] c, input logic w);
        rnd = $random(seed);
        a = rnd[11:0];
        d = rnd[31:16];
        reg_write(4'h0, c | 8'h02);
        arr_write(a, d, w);
        reg_write(4'h0, c | 8'h03);
    endtask

    // bounded wait: a hung sequencer shows as a failed check, not a hang
    task automatic wait_irq;
        int i;
        i = 0;
        while (irq !== 1'b1 && i < 20000) begin
            @(posedge clk);
            i++;
        end
        check("irq after cycle", {15'h0, irq}, 16'h1);
    endtask

    function automatic eepc_size_e exp_size(input logic [7:0] c);
        if (!c[2]) return EEPC_SZ_PROG;
        if (c[4]) return EEPC_SZ_LOC;
        return c[3] ? EEPC_SZ_ROW : EEPC_SZ_BULK;
    endfunction

    // read data stands only in the cycle after the strobe
    always @(posedge clk) rd_q <= reg_rd;
    always @(negedge clk) begin
        if (rd_q) begin
            check(name_q.pop_front(), {8'h0, reg_rdata}, {8'h0, exp_q.pop_front()});
        end
    end

    // watchdog sized for two full cycles plus margin
    initial begin
        #(80000 * 50);
        num_errors++;
        $display("watchdog expired");
        results;
    end

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, arr_wr, arr_word} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        arr_addr = '0;
        arr_wdata = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reg_read(4'h0, 8'h80, "ctrl reset");
        reg_read(4'h3, 8'h00, "status reset");
        check("read mode reset", {15'h0, arr_read_mode}, 16'h1);
        $display("test reset done");
        reg_write(4'h0, 8'h02);
        reg_read(4'h0, 8'h00, "latch with divider zero");
        reg_write(4'h1, 8'h01);
        reg_write(4'h0, 8'h01);
        reg_read(4'h0, 8'h00, "enable without latch");
        reg_write(4'h0, 8'h03);
        reg_read(4'h0, 8'h02, "latch and enable together");
        cyc(1);
        check("read mode off", {15'h0, arr_read_mode}, 16'h0);
        reg_write(4'h0, 8'h06);
        reg_write(4'h0, 8'h16);
        reg_read(4'h0, 8'h16, "separate mode writes");
        $display("test control writes done");
        rnd = $random(seed);
        arr_write(rnd[11:0] | 12'h001, rnd[31:16], 1'b1);
        cyc(1);
        check("word latch addr", {4'h0, lat_addr}, {4'h0, rnd[11:1], 1'b0});
        check("word latch size", {15'h0, lat_word}, 16'h1);
        arr_write(rnd[11:0] | 12'h001, rnd[31:16], 1'b0);
        cyc(1);
        check("byte latch addr", {4'h0, lat_addr}, {4'h0, rnd[11:1], 1'b1});
        check("byte latch size", {15'h0, lat_word}, 16'h0);
        reg_write(4'h0, 8'h00);
        $display("test latch access done");
        // erase size table, each cycle aborted early
        for (int i = 0; i < 5; i++) begin
            rnd = $random(seed);
            ctl = (i == 4) ? (rnd[7:0] & 8'h18) : ctl_tab[i];
            start_op(ctl, 1'b0);
            cyc(3);
            check("voltage on", {15'h0, hv_on}, 16'h1);
            check("erase size", {14'h0, lat_size}, {14'h0, exp_size(ctl)});
            check("erase select", {15'h0, lat_erase}, {15'h0, ctl[2]});
            reg_write(4'h0, ctl | 8'h02);
            reg_write(4'h0, 8'h00);
            cyc(3);
            check("voltage off", {15'h0, hv_on}, 16'h0);
        end
        reg_write(4'h3, 8'h03);
        $display("test erase sizes done");
        // frozen bits and latches during a manual cycle
        reg_write(4'h4, 8'h01);
        start_op(8'h00, 1'b1);
        cyc(2);
        reg_write(4'h0, 8'hBD);
        reg_read(4'h0, 8'h03, "frozen control");
        arr_write(~a, ~d, 1'b1);
        cyc(1);
        check("frozen addr", {4'h0, lat_addr}, {4'h0, a[11:1], 1'b0});
        check("frozen data", lat_data, d);
        reg_read(4'h5, a[11:4], "latched address");
        reg_read(4'h6, d[7:0], "latched data low");
        wait_irq;
        cyc(3);
        reg_read(4'h0, 8'h03, "manual enable kept");
        reg_read(4'h3, 8'h01, "done status");
        reg_write(4'h0, 8'h02);
        reg_write(4'h0, 8'h00);
        reg_write(4'h3, 8'h01);
        cyc(3);
        check("irq cleared", {15'h0, irq}, 16'h0);
        $display("test manual cycle done");
        start_op(8'h24, 1'b0);
        wait_irq;
        cyc(3);
        reg_read(4'h0, 8'h26, "auto enable cleared");
        check("voltage after auto", {15'h0, hv_on}, 16'h0);
        reg_write(4'h0, 8'h00);
        reg_write(4'h3, 8'h01);
        $display("test auto erase done");
        start_op(8'hAC, 1'b0);
        cyc(5);
        check("voltage refused", {15'h0, hv_on}, 16'h0);
        reg_read(4'h0, 8'hAF, "refused enable stays");
        reg_read(4'h3, 8'h02, "refused status");
        check("irq masked", {15'h0, irq}, 16'h0);
        reg_write(4'h4, 8'h02);
        cyc(3);
        check("irq unmasked", {15'h0, irq}, 16'h1);
        reg_write(4'h3, 8'h02);
        cyc(3);
        check("irq after clear", {15'h0, irq}, 16'h0);
        reg_write(4'h0, 8'hAE);
        reg_write(4'h0, 8'h80);
        reg_read(4'h0, 8'h80, "idle control");
        // program into a protected block never starts
        reg_write(4'h2, 8'hFF);
        start_op(8'h00, 1'b0);
        cyc(3);
        check("protected program", {15'h0, hv_on}, 16'h0);
        reg_read(4'h3, 8'h02, "protected status");
        reg_write(4'h0, 8'h02);
        reg_write(4'h0, 8'h00);
        $display("test protection done");
        cyc(3);
        results;
    end
endmodule
